// File: rtl/pxb_pad.sv
// output driver choice for one port pin
`timescale 1ns/10ps

module pxb_pad (
  // routing and configuration
  input  wire logic                        xbar_en,
  input  wire logic [pxb_pkg::FNW-1:0]     fn,
  input  wire logic                        latch,
  input  wire logic                        push_pull,
  // peripheral drive requests
  input  wire logic [pxb_pkg::NUM_FN-1:0]  fn_out,
  input  wire logic [pxb_pkg::NUM_FN-1:0]  fn_oe,
  // resulting drive
  output logic                             drv_val,
  output logic                             drv_en
);

  logic want;
  logic pp;

  // ==========================================================
  // routed function or plain latch; open drain only ever pulls low
  always_comb begin
    drv_val = latch;
    want    = 1'b1;
    pp      = push_pull; // see R15
    if (fn < 5'(pxb_pkg::NUM_FN)) begin
      drv_val = fn_out[fn];
      want    = fn_oe[fn];
      // bus lines stay open drain whatever the mode bit holds
      if (fn == pxb_pkg::FN_SDA || fn == pxb_pkg::FN_SCL) begin
        pp = 1'b0;
      end
    end
    drv_en = xbar_en && want && (pp || !drv_val); // see R18 R7
  end

endmodule // pxb_pad

// File: rtl/pxb_pkg.sv
// constants, codes and register layout shared by the port crossbar
package pxb_pkg;

  // ==========================================================
  // pin layout
  localparam int NUM_PINS  = 29;  // three byte ports plus one 5-bit port
  localparam int NUM_XPINS = 20;  // P0.0 .. P2.3 may carry routed functions
  localparam int NUM_FN    = 21;
  localparam int FNW       = 5;
  localparam int TX_PIN    = 4;
  localparam int RX_PIN    = 5;
  localparam logic [3:0][7:0] PORT_MASK = {8'h1F, 8'hFF, 8'hFF, 8'hFF};

  // ==========================================================
  // function codes; the code is also the placement rank, lowest first
  localparam logic [4:0] FN_TX     = 5'h00; // see R20
  localparam logic [4:0] FN_RX     = 5'h01;
  localparam logic [4:0] FN_SCK    = 5'h02;
  localparam logic [4:0] FN_MISO   = 5'h03;
  localparam logic [4:0] FN_MOSI   = 5'h04;
  localparam logic [4:0] FN_SS     = 5'h05;
  localparam logic [4:0] FN_SDA    = 5'h06;
  localparam logic [4:0] FN_SCL    = 5'h07;
  localparam logic [4:0] FN_CP0    = 5'h08;
  localparam logic [4:0] FN_CP0A   = 5'h09;
  localparam logic [4:0] FN_CP1    = 5'h0A;
  localparam logic [4:0] FN_CP1A   = 5'h0B;
  localparam logic [4:0] FN_SYSCLK = 5'h0C;
  localparam logic [4:0] FN_CEX0   = 5'h0D;
  localparam logic [4:0] FN_ECI    = 5'h12;
  localparam logic [4:0] FN_T0     = 5'h13;
  localparam logic [4:0] FN_T1     = 5'h14;
  localparam logic [4:0] FN_NONE   = 5'h1F;
  localparam logic [2:0] CEX_MAX   = 3'h5;

  // ==========================================================
  // field positions in function_select_a / function_select_b
  localparam int SA_UART   = 0;
  localparam int SA_SPI    = 1;
  localparam int SA_SMB    = 2;
  localparam int SA_SYSCLK = 3;
  localparam int SA_CP0    = 4;
  localparam int SA_CP0A   = 5;
  localparam int SA_CP1    = 6;
  localparam int SA_CP1A   = 7;
  localparam int SB_CEX_LO = 0;
  localparam int SB_ECI    = 3;
  localparam int SB_T0     = 4;
  localparam int SB_T1     = 5;
  localparam int SB_XBAR   = 6;

  // ==========================================================
  // register word indexes, byte address is four times the index
  localparam logic [5:0] WI_SEL_A = 6'h00;
  localparam logic [5:0] WI_SEL_B = 6'h01;
  localparam logic [5:0] WI_SKIP0 = 6'h02;
  localparam logic [5:0] WI_MODE0 = 6'h05;
  localparam logic [5:0] WI_PORT0 = 6'h09;
  localparam logic [5:0] WI_SPI   = 6'h0D;
  localparam logic [5:0] WI_STAT  = 6'h0E;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: rtl/pxb_route.sv
// priority walk that places selected functions onto crossbar pins
`timescale 1ns/10ps

module pxb_route (
  // selected functions and skipped pins
  input  wire logic [pxb_pkg::NUM_FN-1:0]                      func_en,
  input  wire logic [pxb_pkg::NUM_XPINS-1:0]                   skip,
  // placement result
  output logic      [pxb_pkg::NUM_XPINS-1:0][pxb_pkg::FNW-1:0] pin_fn,
  output logic      [pxb_pkg::NUM_XPINS-1:0]                   routed
);

  logic [pxb_pkg::NUM_XPINS-1:0] taken;
  logic                          found;

  // ==========================================================
  // purely combinational so routing follows the registers at once
  always_comb begin // see R21
    taken  = skip; // see R5
    routed = '0;
    found  = 1'b0;
    for (int p = 0; p < pxb_pkg::NUM_XPINS; p++) begin
      pin_fn[p] = pxb_pkg::FN_NONE;
    end
    // uart pair is pinned down whatever the skip mask says
    if (func_en[pxb_pkg::FN_TX]) begin // see R3
      pin_fn[pxb_pkg::TX_PIN] = pxb_pkg::FN_TX;
      pin_fn[pxb_pkg::RX_PIN] = pxb_pkg::FN_RX;
      taken[pxb_pkg::TX_PIN]  = 1'b1;
      taken[pxb_pkg::RX_PIN]  = 1'b1;
      routed[pxb_pkg::TX_PIN] = 1'b1;
      routed[pxb_pkg::RX_PIN] = 1'b1;
    end
    // rank order walk, each function takes the lowest free pin
    for (int f = int'(pxb_pkg::FN_SCK); f < pxb_pkg::NUM_FN; f++) begin // see R1
      found = 1'b0;
      if (func_en[f]) begin
        for (int p = 0; p < pxb_pkg::NUM_XPINS; p++) begin
          if (!found && !taken[p]) begin // see R2 R4
            pin_fn[p] = 5'(f);
            taken[p]  = 1'b1;
            routed[p] = 1'b1;
            found     = 1'b1;
          end
        end
      end
    end
  end

endmodule // pxb_route

// File: rtl/pxb_top.sv
// port crossbar: register slave, priority placement and pin drivers
// How it works
// R1 - functions rank in fixed order, uart highest, and take pins in that order
// R2 - each selected function gets the lowest still unassigned pin
// R3 - selected uart always sits on P0.4 transmit and P0.5 receive
// R4 - pins already given to higher functions are passed over
// R5 - pins marked in a skip mask count as occupied
// R6 - uart functions reserve both their pins together; bus functions take pins one by one and can be split
// R7 - leftover unskipped pins stay general purpose port pins
// R8 - only P0.0 through P2.3 can carry routed functions
// R9 - port data reads return the live pin levels
// R10 - slave select takes a pin only in four wire mode
// R11 - software skips pins used by peripherals outside the crossbar
// R12 - software skips pins of special function signals by hand
// R13 - skip bit n of a port masks pin n of that port
// R14 - smallest variant software sets top two port1 skip bits
// R15 - each pin driver is push pull or open drain by mode register, except bus pins, which stay open drain
// R16 - two select registers choose which functions join placement
// R17 - pins form three byte ports plus one 5-bit port
// R18 - crossbar disabled keeps every pin input with drivers off
// R19 - counter array field n routes channels 0 to n-1, never more than channels 0 to 4
// R20 - rank order below uart is a fixed constant table
// R21 - placement recomputes from registers, pins follow next cycle
`timescale 1ns/10ps

module pxb_top (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        nrst,
  // axi4-lite write
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [7:0]                  s_axi_awaddr,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  output logic      [1:0]                  s_axi_bresp,
  // axi4-lite read
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  input  wire logic [7:0]                  s_axi_araddr,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  output logic      [31:0]                 s_axi_rdata,
  output logic      [1:0]                  s_axi_rresp,
  // port pins
  input  wire logic [pxb_pkg::NUM_PINS-1:0] pin_in,
  output logic      [pxb_pkg::NUM_PINS-1:0] pin_out,
  output logic      [pxb_pkg::NUM_PINS-1:0] pin_oe_n,
  // peripheral side, indexed by function code
  input  wire logic [pxb_pkg::NUM_FN-1:0]   fn_out,
  input  wire logic [pxb_pkg::NUM_FN-1:0]   fn_oe,
  output logic      [pxb_pkg::NUM_FN-1:0]   fn_in
);

  typedef struct packed {
    logic                          awready;
    logic                          wready;
    logic                          arready;
    logic                          bvalid;
    logic [1:0]                    bresp;
    logic                          rvalid;
    logic [31:0]                   rdata;
    logic [1:0]                    rresp;
    logic                          aw_have;
    logic                          w_have;
    logic [5:0]                    waddr;
    logic [7:0]                    wdata;
    logic                          wstb;
    logic [7:0]                    sel_a;
    logic [7:0]                    sel_b;
    logic [2:0][7:0]               skip;
    logic [3:0][7:0]               mode;
    logic [3:0][7:0]               lat;
    logic [1:0]                    ssmode;
    logic [pxb_pkg::NUM_PINS-1:0]  pin_out;
    logic [pxb_pkg::NUM_PINS-1:0]  pin_oe_n;
    logic [pxb_pkg::NUM_FN-1:0]    fn_in;
  } pxb_state_t;

  // latches reset high, drivers off, channels ready
  localparam pxb_state_t ST_RST = '{awready: 1'b1, wready: 1'b1, arready: 1'b1,
                                    lat: pxb_pkg::PORT_MASK, pin_oe_n: '1, fn_in: '1, default: '0};

  pxb_state_t                                       q;
  pxb_state_t                                       d;
  logic                                             rst_s1_q;
  logic                                             rst_n_q;
  logic                                             xbar_en;
  logic [pxb_pkg::NUM_FN-1:0]                       func_en;
  logic [pxb_pkg::NUM_XPINS-1:0]                    skip_all;
  logic [pxb_pkg::NUM_XPINS-1:0][pxb_pkg::FNW-1:0]  pin_fn;
  logic [pxb_pkg::NUM_XPINS-1:0]                    routed;
  logic [pxb_pkg::NUM_PINS-1:0][pxb_pkg::FNW-1:0]   fn_all;
  logic [pxb_pkg::NUM_PINS-1:0]                     drv_val;
  logic [pxb_pkg::NUM_PINS-1:0]                     drv_en;
  logic [3:0][7:0]                                  pin_bytes;
  logic [5:0]                                       wi;
  logic [5:0]                                       ri;
  logic [5:0]                                       kw;
  logic [5:0]                                       kr;
  logic                                             wr_ok;
  logic                                             rd_ok;
  logic [31:0]                                      rd_val;

  // ==========================================================
  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // ==========================================================
  // function selection from the two select registers
  assign xbar_en = q.sel_b[pxb_pkg::SB_XBAR];
  always_comb begin // see R16
    func_en = '0;
    func_en[pxb_pkg::FN_TX]     = q.sel_a[pxb_pkg::SA_UART]; // see R6
    func_en[pxb_pkg::FN_RX]     = q.sel_a[pxb_pkg::SA_UART];
    func_en[pxb_pkg::FN_SCK]    = q.sel_a[pxb_pkg::SA_SPI];
    func_en[pxb_pkg::FN_MISO]   = q.sel_a[pxb_pkg::SA_SPI];
    func_en[pxb_pkg::FN_MOSI]   = q.sel_a[pxb_pkg::SA_SPI];
    func_en[pxb_pkg::FN_SS]     = q.sel_a[pxb_pkg::SA_SPI] && (q.ssmode != 2'h0); // see R10
    func_en[pxb_pkg::FN_SDA]    = q.sel_a[pxb_pkg::SA_SMB]; // see R6
    func_en[pxb_pkg::FN_SCL]    = q.sel_a[pxb_pkg::SA_SMB];
    func_en[pxb_pkg::FN_CP0]    = q.sel_a[pxb_pkg::SA_CP0];
    func_en[pxb_pkg::FN_CP0A]   = q.sel_a[pxb_pkg::SA_CP0A];
    func_en[pxb_pkg::FN_CP1]    = q.sel_a[pxb_pkg::SA_CP1];
    func_en[pxb_pkg::FN_CP1A]   = q.sel_a[pxb_pkg::SA_CP1A];
    func_en[pxb_pkg::FN_SYSCLK] = q.sel_a[pxb_pkg::SA_SYSCLK];
    // channel i joins when the field exceeds i
    for (int i = 0; i < int'(pxb_pkg::CEX_MAX); i++) begin // see R19
      func_en[int'(pxb_pkg::FN_CEX0) + i] = q.sel_b[pxb_pkg::SB_CEX_LO +: 3] > 3'(i);
    end
    func_en[pxb_pkg::FN_ECI]    = q.sel_b[pxb_pkg::SB_ECI];
    func_en[pxb_pkg::FN_T0]     = q.sel_b[pxb_pkg::SB_T0];
    func_en[pxb_pkg::FN_T1]     = q.sel_b[pxb_pkg::SB_T1];
  end

  // skip bit n of a port lines up with pin n; port2 stops at pin 3
  assign skip_all  = {q.skip[2][3:0], q.skip[1], q.skip[0]}; // see R13 R8
  assign fn_all    = {{(pxb_pkg::NUM_PINS - pxb_pkg::NUM_XPINS){pxb_pkg::FN_NONE}}, pin_fn}; // see R8 R17
  assign pin_bytes = {3'h0, pin_in};

  pxb_route u_route (
    .func_en (func_en),
    .skip    (skip_all),
    .pin_fn  (pin_fn),
    .routed  (routed)
  );

  genvar g;
  generate
    for (g = 0; g < pxb_pkg::NUM_PINS; g++) begin : g_pad
      pxb_pad u_pad (
        .xbar_en   (xbar_en),
        .fn        (fn_all[g]),
        .latch     (q.lat[g / 8][g % 8]),
        .push_pull (q.mode[g / 8][g % 8]),
        .fn_out    (fn_out),
        .fn_oe     (fn_oe),
        .drv_val   (drv_val[g]),
        .drv_en    (drv_en[g])
      );
    end
  endgenerate

  // ==========================================================
  // next state: bus channels, register writes, read mux, pin flops
  always_comb begin
    d      = q;
    wi     = q.waddr;
    ri     = s_axi_araddr[7:2];
    kw     = wi - pxb_pkg::WI_SKIP0;
    kr     = ri - pxb_pkg::WI_SKIP0;
    wr_ok  = 1'b1;
    rd_ok  = 1'b1;
    rd_val = 32'h0000_0000;
    // address and data are taken independently, in either order
    if (q.awready && s_axi_awvalid) begin
      d.awready = 1'b0;
      d.aw_have = 1'b1;
      d.waddr   = s_axi_awaddr[7:2];
    end
    if (q.wready && s_axi_wvalid) begin
      d.wready = 1'b0;
      d.w_have = 1'b1;
      d.wdata  = s_axi_wdata[7:0];
      d.wstb   = s_axi_wstrb[0];
    end
    // registers are one byte wide, so lane 0 alone carries data
    if (q.aw_have && q.w_have && !q.bvalid) begin
      if (wi == pxb_pkg::WI_SEL_A) begin
        if (q.wstb) d.sel_a = q.wdata;
      end else if (wi == pxb_pkg::WI_SEL_B) begin
        if (q.wstb) d.sel_b = q.wdata;
      end else if (wi >= pxb_pkg::WI_SKIP0 && wi < pxb_pkg::WI_MODE0) begin
        if (q.wstb) d.skip[kw[1:0]] = q.wdata;
      end else if (wi >= pxb_pkg::WI_MODE0 && wi < pxb_pkg::WI_PORT0) begin
        kw = wi - pxb_pkg::WI_MODE0;
        if (q.wstb) d.mode[kw[1:0]] = q.wdata & pxb_pkg::PORT_MASK[kw[1:0]];
      end else if (wi >= pxb_pkg::WI_PORT0 && wi < pxb_pkg::WI_SPI) begin
        kw = wi - pxb_pkg::WI_PORT0;
        if (q.wstb) d.lat[kw[1:0]] = q.wdata & pxb_pkg::PORT_MASK[kw[1:0]];
      end else if (wi == pxb_pkg::WI_SPI) begin
        if (q.wstb) d.ssmode = q.wdata[1:0];
      end else if (wi != pxb_pkg::WI_STAT) begin
        wr_ok = 1'b0;
      end
      d.bvalid  = 1'b1;
      d.bresp   = wr_ok ? pxb_pkg::RESP_OKAY : pxb_pkg::RESP_SLVERR;
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid  = 1'b0;
      d.awready = 1'b1;
      d.wready  = 1'b1;
    end
    // read mux; port words show the pins, not the latches
    if (ri == pxb_pkg::WI_SEL_A) begin
      rd_val[7:0] = q.sel_a;
    end else if (ri == pxb_pkg::WI_SEL_B) begin
      rd_val[7:0] = q.sel_b;
    end else if (ri >= pxb_pkg::WI_SKIP0 && ri < pxb_pkg::WI_MODE0) begin
      rd_val[7:0] = q.skip[kr[1:0]];
    end else if (ri >= pxb_pkg::WI_MODE0 && ri < pxb_pkg::WI_PORT0) begin
      kr = ri - pxb_pkg::WI_MODE0;
      rd_val[7:0] = q.mode[kr[1:0]];
    end else if (ri >= pxb_pkg::WI_PORT0 && ri < pxb_pkg::WI_SPI) begin
      kr = ri - pxb_pkg::WI_PORT0;
      rd_val[7:0] = pin_bytes[kr[1:0]]; // see R9
    end else if (ri == pxb_pkg::WI_SPI) begin
      rd_val[1:0] = q.ssmode;
    end else if (ri == pxb_pkg::WI_STAT) begin
      rd_val[pxb_pkg::NUM_XPINS-1:0] = routed;
    end else begin
      rd_ok = 1'b0;
    end
    if (q.arready && s_axi_arvalid) begin
      d.arready = 1'b0;
      d.rvalid  = 1'b1;
      d.rdata   = rd_val;
      d.rresp   = rd_ok ? pxb_pkg::RESP_OKAY : pxb_pkg::RESP_SLVERR;
    end
    if (q.rvalid && s_axi_rready) begin
      d.rvalid  = 1'b0;
      d.arready = 1'b1;
    end
    // pins land one cycle after the registers change
    d.pin_out  = drv_val; // see R21
    d.pin_oe_n = ~drv_en;
    // inputs idle high when their function holds no pin
    d.fn_in = '1;
    for (int p = 0; p < pxb_pkg::NUM_XPINS; p++) begin
      if (xbar_en && pin_fn[p] != pxb_pkg::FN_NONE) d.fn_in[pin_fn[p]] = pin_in[p];
    end
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready  = q.wready;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign pin_out       = q.pin_out;
  assign pin_oe_n      = q.pin_oe_n;
  assign fn_in         = q.fn_in;

  // ==========================================================
  // checks; helper views of the placement
  logic       seen_free;
  logic       gap_bad;
  logic       ss_placed;
  logic       sda_on;
  logic       scl_on;
  logic [2:0] cex_pins;
  logic [2:0] cex_want;
  logic [pxb_pkg::NUM_XPINS-1:0] uart_mask;

  always_comb begin
    seen_free = 1'b0;
    gap_bad   = 1'b0;
    ss_placed = 1'b0;
    sda_on    = 1'b0;
    scl_on    = 1'b0;
    cex_pins  = 3'h0;
    uart_mask = '0;
    uart_mask[pxb_pkg::TX_PIN] = func_en[pxb_pkg::FN_TX];
    uart_mask[pxb_pkg::RX_PIN] = func_en[pxb_pkg::FN_TX];
    cex_want  = (q.sel_b[2:0] > pxb_pkg::CEX_MAX) ? pxb_pkg::CEX_MAX : q.sel_b[2:0];
    for (int p = 0; p < pxb_pkg::NUM_XPINS; p++) begin
      if (!skip_all[p] && !routed[p]) seen_free = 1'b1;
      else if (routed[p] && !uart_mask[p] && seen_free) gap_bad = 1'b1;
      if (pin_fn[p] == pxb_pkg::FN_SS) ss_placed = 1'b1;
      if (pin_fn[p] == pxb_pkg::FN_SDA) sda_on = 1'b1;
      if (pin_fn[p] == pxb_pkg::FN_SCL) scl_on = 1'b1;
      if (pin_fn[p] >= pxb_pkg::FN_CEX0 && pin_fn[p] < pxb_pkg::FN_ECI) cex_pins = cex_pins + 3'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n_q);

  sequence s_sel_b_off;
    s_axi_awvalid && s_axi_awready && s_axi_awaddr[7:2] == pxb_pkg::WI_SEL_B &&
    s_axi_wvalid && s_axi_wready && s_axi_wstrb[0] && !s_axi_wdata[pxb_pkg::SB_XBAR];
  endsequence
  sequence s_write_done;
    ##2 s_axi_bvalid ##1 (&pin_oe_n);
  endsequence
  sequence s_port0_read;
    s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == pxb_pkg::WI_PORT0;
  endsequence

  a_uart_pins_fixed: // see R3
    assert property (func_en[pxb_pkg::FN_TX] |-> pin_fn[pxb_pkg::TX_PIN] == pxb_pkg::FN_TX &&
                     pin_fn[pxb_pkg::RX_PIN] == pxb_pkg::FN_RX) else $error("uart pins misplaced");
  a_skip_honoured: // see R5
    assert property ((routed & skip_all & ~uart_mask) == '0) else $error("skipped pin was routed");
  a_lowest_free: // see R2
    assert property (!gap_bad) else $error("function placed above a free pin");
  a_ss_three_wire: // see R10
    assert property (q.ssmode == 2'h0 |-> !ss_placed) else $error("slave select placed in 3-wire mode");
  a_cex_count: // see R19
    assert property (skip_all == '0 |-> cex_pins == cex_want) else $error("counter channel count wrong");
  a_bus_pair: // see R6
    assert property (skip_all == '0 && q.sel_a[pxb_pkg::SA_SMB] |-> sda_on && scl_on) else $error("bus pair split");
  a_xbar_quiet: // see R18
    assert property (!xbar_en |=> &pin_oe_n) else $error("driver on while crossbar off");
  a_route_latency: // see R21
    assert property (s_sel_b_off |-> s_write_done) else $error("crossbar disable not applied in time");
  a_pin_readback: // see R9
    assert property (s_port0_read |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(pin_in[7:0]))
    else $error("port read does not show pins");

endmodule // pxb_top

// File: verification/pxb_far_model.sv
// far side model: port pins resolved against the outside world
`timescale 1ns/10ps

module pxb_far_model (
  // design drive
  input  wire logic [pxb_pkg::NUM_PINS-1:0] pin_out,
  input  wire logic [pxb_pkg::NUM_PINS-1:0] pin_oe_n,
  // outside level on released pins
  input  wire logic [pxb_pkg::NUM_PINS-1:0] ext_lvl,
  // level seen on the pins
  output logic      [pxb_pkg::NUM_PINS-1:0] pin_lvl
);
  // a released pin never keeps the design's last value, it shows the outside level
  always_comb begin
    for (int i = 0; i < pxb_pkg::NUM_PINS; i++) begin
      pin_lvl[i] = pin_oe_n[i] ? ext_lvl[i] : pin_out[i];
    end
  end
endmodule // pxb_far_model

// File: verification/tb_priority_pin_crossbar.sv
// self-checking bench for the port crossbar
`timescale 1ns/10ps

module tb_priority_pin_crossbar;
  // ==========================================================
  // signals
  logic        clk = 1'b0;
  logic        nrst;
  logic        s_axi_awvalid = 1'b0, s_axi_awready, s_axi_wvalid = 1'b0, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_arready, s_axi_rvalid, s_axi_rready = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'h1;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [28:0] pin_in, pin_out, pin_oe_n, ext_lvl = '1;
  logic [20:0] fn_out = '0, fn_oe = '0, fn_in;
  int          miscompares = 0, checked = 0, pl[21];
  // rows of {select a, select b, spi mode, skip}: overflow, uart on skipped pins, lone smbus pin, 3-wire spi
  localparam logic [3:0][43:0] CORNER = {44'h02_00_00_0000C, 44'h04_00_00_FFFFE, 44'h01_00_00_0003C,
                                         44'hFF_3D_01_00000};

  pxb_top uut (.clk, .nrst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .pin_in, .pin_out, .pin_oe_n,
    .fn_out, .fn_oe, .fn_in);
  pxb_far_model far (.pin_out, .pin_oe_n, .ext_lvl, .pin_lvl(pin_in));

  // clock of 50 ns period
  always #25 clk = ~clk;

  // ==========================================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic test_done();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // reference walk: uart fixed, then rank order onto lowest free pin below 20
  function automatic void place(input logic [7:0] sa, sb, sm, input logic [19:0] sk);
    logic [20:0] en;
    logic [19:0] oc;
    en = {sb[5:3], 5'h0, sa[3], sa[7:4], {2{sa[2]}}, sa[1] && sm[1:0] != 2'h0, {3{sa[1]}}, {2{sa[0]}}};
    for (int c = 0; c < 5; c++) en[13+c] = c < sb[2:0];
    oc = sk | (sa[0] ? 20'h30 : 20'h0);
    for (int f = 0; f < 21; f++) begin
      pl[f] = (f < 2 && en[f]) ? 4 + f : -1;
      for (int p = 0; p < 20; p++) begin
        if (f >= 2 && en[f] && pl[f] < 0 && !oc[p]) begin
          pl[f] = p;
          oc[p] = 1'b1;
        end
      end
    end
  endfunction

  // program a placement, then check every function input, the routed map and a port read
  task automatic run(input logic [7:0] sa, sb, sm, input logic [19:0] sk);
    logic [19:0] st;
    wr(8'h00, sa);
    wr(8'h04, sb | 8'h40);
    wr(8'h08, sk[7:0]);
    wr(8'h0C, sk[15:8]);
    wr(8'h10, {4'h0, sk[19:16]});
    wr(8'h34, sm);
    ext_lvl <= 29'($urandom);
    place(sa, sb, sm, sk);
    repeat (3) @(posedge clk);
    st = '0;
    for (int f = 0; f < 21; f++) begin
      chk(fn_in[f], pl[f] < 0 ? 1'b1 : ext_lvl[pl[f]], "fn_in");
      if (pl[f] >= 0) st[pl[f]] = 1'b1;
    end
    rdr(8'h38);
    chk(rd, {12'h0, st}, "routed");
    rdr(8'h24);
    chk(rd, {24'h0, ext_lvl[7:0]}, "port0");
    chk(rsp, pxb_pkg::RESP_OKAY, "port0 resp");
  endtask

  // watchdog far beyond the expected run
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    test_done();
  end

  // main sequence
  initial begin
    void'($urandom(17));
    nrst <= 1'b0; // edge at time zero resets the flops before the first clock
    repeat (16) @(posedge clk);
    chk(pin_oe_n, 32'h1FFFFFFF, "reset drive");
    chk(fn_in, 32'h1FFFFF, "reset fn_in");
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 40; i++) begin
      if (i < 4)
        run(CORNER[i][43:36], CORNER[i][35:28], CORNER[i][27:20], CORNER[i][19:0]);
      else
        run(8'($urandom), 8'($urandom), 8'($urandom), 20'($urandom));
    end
    run(8'h01, 8'h00, 8'h00, 20'h0);
    fn_oe <= 21'h1;
    fn_out <= 21'h1FFFFE;
    repeat (3) @(posedge clk);
    chk({pin_oe_n[4], pin_out[4]}, 2'b00, "tx low");
    fn_out <= 21'h1;
    repeat (3) @(posedge clk);
    chk(pin_oe_n[4], 1'b1, "tx open drain");
    wr(8'h14, 8'h10);
    repeat (3) @(posedge clk);
    chk({pin_oe_n[4], pin_out[4]}, 2'b01, "tx push pull");
    wr(8'h24, 8'h00);
    repeat (3) @(posedge clk);
    chk({pin_oe_n[0], pin_out[0]}, 2'b00, "gpio latch low");
    wr(8'h04, 8'h00);
    repeat (3) @(posedge clk);
    chk(pin_oe_n, 32'h1FFFFFFF, "xbar off");
    wr(8'h3C, 8'hA5);
    chk(rsp, pxb_pkg::RESP_SLVERR, "bad write");
    rdr(8'hFC);
    chk(rsp, pxb_pkg::RESP_SLVERR, "bad read");
    test_done();
  end
endmodule // tb_priority_pin_crossbar
